// [charger_input_limit_control.sv]
// charger input limit control: registers, supply sequencing, limit source
`timescale 1ns/1ns
// Notes on behaviour
// R01: buck input limit is 4-bit register code
// R02: below floor, step active limit down
// R03: at minimum and collapsed, disable buck
// R04: recovered input steps limit back up
// R05: attach comparator flags 100 mV drop
// R06: comparator output readable in status register
// R07: host programs floor above regulator outputs
// R08: external diode fet only when enabled
// R09: one bit selects automatic USB detection
// R10: not automatic: load wall or USB limit
// R11: D- high picks USB limit, low keeps
// R12: host clears autodetect after powering PHY
// R13: host software writes limit over interface
// R14: USB attach: debounce 10 ms, read settings
// R15: drive D+/D- detection, short means charger
// R16: rail collapse with fault returns to reset
// R17: emergency mode suppresses auto boot, charges
// R18: notify outputs blink in emergency if enabled
// R19: input floor is a 3-bit field
// R20: wall input loads wall limit, has priority
// R21: dedicated charger loads USB charger limit
// R22: host may change limit while charging
// R23: one code per step, clamped both ends
// R24: enter emergency on fault with weak USB
module charger_input_limit_control #(
    parameter int unsigned DEBOUNCE_CYCLES = input_limit_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned DETECT_CYCLES = input_limit_pkg::DETECT_CYCLES,
    parameter int unsigned STEP_CYCLES = input_limit_pkg::STEP_CYCLES,
    parameter int unsigned BLINK_CYCLES = input_limit_pkg::BLINK_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] otp_buck_limit_i,
    input wire logic [7:0] otp_limit_set_i,
    input wire logic [7:0] otp_chg_cont_i,
    input wire logic wall_supply_input_i,
    input wire logic usb_vbus_i,
    input wire logic below_floor_i,
    input wire logic attach_drop_comparator_i,
    input wire logic dminus_level_i,
    input wire logic dedicated_short_i,
    input wire logic supply_fault_i,
    input wire logic battery_ready_i,
    input wire logic diode_engaged_i,
    output logic [3:0] active_input_limit_o,
    output logic [2:0] input_voltage_floor_o,
    output logic buck_en_o,
    output logic buck_low_power_o,
    output logic detect_drive_o,
    output logic ext_fet_en_o,
    output logic auto_boot_en_o,
    output logic reset_mode_o,
    output logic notify_out_a_o,
    output logic notify_out_b_o
);
    localparam int unsigned DBW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam int unsigned DTW = $clog2(DETECT_CYCLES + 1);
    localparam int unsigned BKW = $clog2(BLINK_CYCLES + 1);

    if (DEBOUNCE_CYCLES < 1 || DETECT_CYCLES < 1 || BLINK_CYCLES < 1) begin : g_bad_counts
        $error("charger_input_limit_control: counts must be at least one");
    end

    function automatic logic [3:0] field4(input logic [7:0] r, input int unsigned lsb);
        field4 = r[lsb +: 4];
    endfunction : field4

    input_limit_pkg::power_state_t state_q;
    input_limit_pkg::power_state_t state_d;
    logic [7:0] buck_limit_q;
    logic [7:0] limit_set_q;
    logic [7:0] chg_cont_q;
    logic [7:0] ext_diode_q;
    logic [7:0] notify_q;
    logic [DBW-1:0] deb_cnt_q;
    logic [DTW-1:0] det_cnt_q;
    logic [BKW-1:0] blink_cnt_q;
    logic blink_q;
    logic collapse_q;
    logic dedicated_q;
    logic wall_q;
    logic [3:0] working;
    logic supply_present;
    logic deb_done;
    logic det_done;
    logic load_en;
    logic [3:0] load_val;
    logic running;
    logic at_min;
    logic [7:0] status;

    assign supply_present = wall_supply_input_i | usb_vbus_i;
    assign deb_done = deb_cnt_q == DBW'(DEBOUNCE_CYCLES - 1);
    assign det_done = det_cnt_q == DTW'(DETECT_CYCLES - 1);
    assign running = state_q == input_limit_pkg::ST_ACTIVE || state_q == input_limit_pkg::ST_EMERGENCY;
    assign at_min = working == input_limit_pkg::LIMIT_MIN;

    ////////////////////////////////////////////////////////////////////////
    // supply sequencing state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            input_limit_pkg::ST_OFF: begin
                if (supply_present) begin
                    state_d = input_limit_pkg::ST_DEBOUNCE;
                end
            end
            input_limit_pkg::ST_DEBOUNCE: begin
                if (!supply_present) begin
                    state_d = input_limit_pkg::ST_OFF;
                end else if (deb_done) begin
                    state_d = input_limit_pkg::ST_LOAD; // [R14]
                end
            end
            input_limit_pkg::ST_LOAD: begin
                if (usb_vbus_i && !wall_supply_input_i && otp_buck_limit_i[input_limit_pkg::BL_AUTODETECT]) begin
                    state_d = input_limit_pkg::ST_DETECT; // [R09] [R15]
                end else begin
                    state_d = input_limit_pkg::ST_ACTIVE;
                end
            end
            input_limit_pkg::ST_DETECT: begin
                if (!supply_present) begin
                    state_d = input_limit_pkg::ST_OFF;
                end else if (det_done) begin
                    state_d = input_limit_pkg::ST_ACTIVE;
                end
            end
            input_limit_pkg::ST_ACTIVE: begin
                if (!supply_present) begin
                    state_d = input_limit_pkg::ST_OFF;
                end else if (supply_fault_i && !wall_supply_input_i && !dedicated_q && !battery_ready_i) begin
                    state_d = input_limit_pkg::ST_EMERGENCY; // [R24]
                end else if (supply_fault_i) begin
                    state_d = input_limit_pkg::ST_OFF; // [R16]
                end
            end
            input_limit_pkg::ST_EMERGENCY: begin
                if (!supply_present) begin
                    state_d = input_limit_pkg::ST_OFF;
                end else if (battery_ready_i) begin
                    state_d = input_limit_pkg::ST_ACTIVE; // [R24]
                end
            end
            default: begin
                state_d = input_limit_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= input_limit_pkg::ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debounce and detection timers
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            deb_cnt_q <= '0;
        end else if (state_q != input_limit_pkg::ST_DEBOUNCE || deb_done) begin
            deb_cnt_q <= '0;
        end else begin
            deb_cnt_q <= deb_cnt_q + DBW'(1); // [R14]
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            det_cnt_q <= '0;
            dedicated_q <= 1'b0;
        end else if (state_q == input_limit_pkg::ST_DETECT) begin
            det_cnt_q <= det_cnt_q + DTW'(1);
            if (det_done) begin
                dedicated_q <= dedicated_short_i; // [R15]
            end
        end else begin
            det_cnt_q <= '0;
            if (state_q == input_limit_pkg::ST_OFF) begin
                dedicated_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // limit source selection
    always_comb begin
        load_en = 1'b0;
        load_val = field4(buck_limit_q, input_limit_pkg::BL_LIMIT_LSB);
        if (state_q == input_limit_pkg::ST_LOAD) begin
            load_val = field4(otp_buck_limit_i, input_limit_pkg::BL_LIMIT_LSB); // [R11] [R14] [R21]
            if (wall_supply_input_i) begin
                load_en = 1'b1;
                load_val = field4(otp_limit_set_i, input_limit_pkg::LS_WALL_LSB); // [R10] [R20]
            end else if (!otp_buck_limit_i[input_limit_pkg::BL_AUTODETECT]) begin
                load_en = 1'b1;
                if (dminus_level_i) begin
                    load_val = field4(otp_limit_set_i, input_limit_pkg::LS_USB_LSB); // [R10] [R11]
                end
            end
        end else if (state_q == input_limit_pkg::ST_DETECT && det_done && dedicated_short_i) begin
            load_en = 1'b1;
            load_val = field4(limit_set_q, input_limit_pkg::LS_USB_LSB); // [R21]
        end else if (running && wall_supply_input_i && !wall_q) begin
            load_en = 1'b1;
            load_val = field4(limit_set_q, input_limit_pkg::LS_WALL_LSB); // [R20]
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wall_q <= 1'b0;
        end else begin
            wall_q <= wall_supply_input_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file: settings read on load, host writes otherwise
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buck_limit_q <= input_limit_pkg::RST_BUCK_LIMIT;
            limit_set_q <= input_limit_pkg::RST_LIMIT_SET;
            chg_cont_q <= input_limit_pkg::RST_CHG_CONT;
        end else if (state_q == input_limit_pkg::ST_LOAD) begin
            buck_limit_q <= {otp_buck_limit_i[7:4], load_val}; // [R14]
            limit_set_q <= otp_limit_set_i;
            chg_cont_q <= otp_chg_cont_i;
        end else begin
            if (reg_wr_i && reg_addr_i == input_limit_pkg::ADDR_BUCK_LIMIT) begin
                buck_limit_q <= reg_wdata_i; // [R01] [R09] [R22]
            end
            if (load_en) begin
                buck_limit_q[input_limit_pkg::BL_LIMIT_LSB +: 4] <= load_val; // [R01]
            end
            if (reg_wr_i && reg_addr_i == input_limit_pkg::ADDR_LIMIT_SET) begin
                limit_set_q <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == input_limit_pkg::ADDR_CHG_CONT) begin
                chg_cont_q <= reg_wdata_i; // [R19]
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_diode_q <= input_limit_pkg::RST_EXT_DIODE;
            notify_q <= input_limit_pkg::RST_NOTIFY;
        end else if (reg_wr_i) begin
            if (reg_addr_i == input_limit_pkg::ADDR_EXT_DIODE) begin
                ext_diode_q <= reg_wdata_i;
            end
            if (reg_addr_i == input_limit_pkg::ADDR_NOTIFY) begin
                notify_q <= reg_wdata_i;
            end
        end
    end

    always_comb begin
        status = '0;
        status[input_limit_pkg::ST_ATTACH] = attach_drop_comparator_i; // [R05] [R06]
        status[input_limit_pkg::ST_WALL] = wall_supply_input_i;
        status[input_limit_pkg::ST_USB] = usb_vbus_i;
        status[input_limit_pkg::ST_BUCK_ON] = buck_en_o;
        status[input_limit_pkg::ST_EMERG] = state_q == input_limit_pkg::ST_EMERGENCY;
        status[input_limit_pkg::ST_DEDICATED] = dedicated_q;
        status[input_limit_pkg::ST_AT_MIN] = at_min;
        status[input_limit_pkg::ST_COLLAPSE] = collapse_q;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                input_limit_pkg::ADDR_CMP_STATUS: reg_rdata_o <= status; // [R06]
                input_limit_pkg::ADDR_EXT_DIODE: reg_rdata_o <= ext_diode_q;
                input_limit_pkg::ADDR_BUCK_LIMIT: reg_rdata_o <= buck_limit_q;
                input_limit_pkg::ADDR_LIMIT_SET: reg_rdata_o <= limit_set_q;
                input_limit_pkg::ADDR_CHG_CONT: reg_rdata_o <= chg_cont_q;
                input_limit_pkg::ADDR_NOTIFY: reg_rdata_o <= notify_q;
                default: reg_rdata_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current limit stepping and collapse handling
    limit_stepper #(
        .WIDTH(input_limit_pkg::LIMIT_W),
        .STEP_CYCLES(STEP_CYCLES)
    ) u_stepper (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .run_i(running),
        .below_floor_i(below_floor_i),
        .target_i(field4(buck_limit_q, input_limit_pkg::BL_LIMIT_LSB)),
        .working_o(working)
    );

    assign active_input_limit_o = working;

    // buck stays off until the input is back above the floor
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            collapse_q <= 1'b0;
        end else if (!running || !below_floor_i) begin
            collapse_q <= 1'b0; // [R04]
        end else if (at_min && !attach_drop_comparator_i) begin
            collapse_q <= 1'b1; // [R03] [R05]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // emergency notification blink
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (state_q != input_limit_pkg::ST_EMERGENCY) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
        end else if (blink_cnt_q == BKW'(BLINK_CYCLES - 1)) begin
            blink_cnt_q <= '0;
            blink_q <= !blink_q; // [R18]
        end else begin
            blink_cnt_q <= blink_cnt_q + BKW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buck_en_o <= 1'b0;
            buck_low_power_o <= 1'b0;
            detect_drive_o <= 1'b0;
            ext_fet_en_o <= 1'b0;
            auto_boot_en_o <= 1'b0;
            reset_mode_o <= 1'b1;
            notify_out_a_o <= 1'b0;
            notify_out_b_o <= 1'b0;
            input_voltage_floor_o <= '0;
        end else begin
            buck_en_o <= running && buck_limit_q[input_limit_pkg::BL_BUCK_EN] && !collapse_q; // [R03]
            buck_low_power_o <= buck_limit_q[input_limit_pkg::BL_LOW_POWER];
            detect_drive_o <= state_q == input_limit_pkg::ST_DETECT; // [R15]
            ext_fet_en_o <= ext_diode_q[input_limit_pkg::ED_FET_EN] && diode_engaged_i; // [R08]
            auto_boot_en_o <= state_q == input_limit_pkg::ST_ACTIVE; // [R17]
            reset_mode_o <= state_q == input_limit_pkg::ST_OFF || state_q == input_limit_pkg::ST_DEBOUNCE; // [R16]
            notify_out_a_o <= notify_q[input_limit_pkg::NT_BLINK_EN] && blink_q; // [R18]
            notify_out_b_o <= notify_q[input_limit_pkg::NT_BLINK_EN] && !blink_q
                && state_q == input_limit_pkg::ST_EMERGENCY; // [R18]
            input_voltage_floor_o <= chg_cont_q[input_limit_pkg::CC_FLOOR_LSB +: 3]; // [R19]
        end
    end
endmodule : charger_input_limit_control

// [input_limit_pkg.sv]
// constants for the charger input limit control block
package input_limit_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned LIMIT_W = 4;
    localparam int unsigned FLOOR_W = 3;
    // register addresses
    localparam logic [7:0] ADDR_CMP_STATUS = 8'h02;
    localparam logic [7:0] ADDR_EXT_DIODE = 8'h0F;
    localparam logic [7:0] ADDR_BUCK_LIMIT = 8'h3E;
    localparam logic [7:0] ADDR_LIMIT_SET = 8'h40;
    localparam logic [7:0] ADDR_CHG_CONT = 8'h42;
    localparam logic [7:0] ADDR_NOTIFY = 8'h50;
    // buck_limit_control fields
    localparam int unsigned BL_LIMIT_LSB = 0;
    localparam int unsigned BL_BUCK_EN = 4;
    localparam int unsigned BL_LOW_POWER = 5;
    localparam int unsigned BL_AUTODETECT = 6;
    localparam int unsigned BL_TEMP_CTRL = 7;
    // limit setting fields
    localparam int unsigned LS_USB_LSB = 0;
    localparam int unsigned LS_WALL_LSB = 4;
    // charge control fields
    localparam int unsigned CC_FLOOR_LSB = 0;
    // ext_diode_control and notify fields
    localparam int unsigned ED_FET_EN = 0;
    localparam int unsigned NT_BLINK_EN = 0;
    // comparator status fields
    localparam int unsigned ST_ATTACH = 0;
    localparam int unsigned ST_WALL = 1;
    localparam int unsigned ST_USB = 2;
    localparam int unsigned ST_BUCK_ON = 3;
    localparam int unsigned ST_EMERG = 4;
    localparam int unsigned ST_DEDICATED = 5;
    localparam int unsigned ST_AT_MIN = 6;
    localparam int unsigned ST_COLLAPSE = 7;
    // values after reset, before the one-time settings are read
    localparam logic [7:0] RST_BUCK_LIMIT = 8'h00;
    localparam logic [7:0] RST_LIMIT_SET = 8'h00;
    localparam logic [7:0] RST_CHG_CONT = 8'h00;
    localparam logic [7:0] RST_EXT_DIODE = 8'h00;
    localparam logic [7:0] RST_NOTIFY = 8'h00;
    localparam logic [3:0] LIMIT_MIN = 4'h0;
    // timing
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned DETECT_US = 1000;
    localparam int unsigned DETECT_CYCLES = DETECT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STEP_US = 100;
    localparam int unsigned STEP_CYCLES = STEP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_DEBOUNCE = 3'b001,
        ST_LOAD = 3'b010,
        ST_DETECT = 3'b011,
        ST_ACTIVE = 3'b100,
        ST_EMERGENCY = 3'b101
    } power_state_t;
endpackage : input_limit_pkg

// [limit_stepper.sv]
// steps the working input current limit toward its target or minimum
`timescale 1ns/1ns
module limit_stepper #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned STEP_CYCLES = 2500
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic below_floor_i,
    input wire logic [WIDTH-1:0] target_i,
    output logic [WIDTH-1:0] working_o
);
    localparam int unsigned CW = $clog2(STEP_CYCLES + 1);

    logic [CW-1:0] div_q;
    logic step_q;

    if (STEP_CYCLES < 1 || WIDTH < 1) begin : g_bad_params
        $error("limit_stepper: bad parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // step interval divider
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q <= '0;
            step_q <= 1'b0;
        end else if (!run_i || div_q == CW'(STEP_CYCLES - 1)) begin
            div_q <= '0;
            step_q <= run_i;
        end else begin
            div_q <= div_q + CW'(1);
            step_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one code per interval, clamped to minimum and target
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            working_o <= '0;
        end else if (!run_i) begin
            working_o <= '0;
        end else if (working_o > target_i) begin
            working_o <= target_i; // [R23]
        end else if (step_q && below_floor_i && working_o != '0) begin
            working_o <= working_o - WIDTH'(1); // [R02] [R23]
        end else if (step_q && !below_floor_i && working_o < target_i) begin
            working_o <= working_o + WIDTH'(1); // [R04] [R23]
        end
    end
endmodule : limit_stepper

// [charger_input_limit_control_asserts.sv]
// assertions on the charger input limit control ports
`timescale 1ns/1ns
module charger_input_limit_control_asserts #(
    parameter int unsigned STEP_CYCLES = 2500
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic below_floor_i,
    input wire logic attach_drop_comparator_i,
    input wire logic usb_vbus_i,
    input wire logic [3:0] active_input_limit_o,
    input wire logic buck_en_o,
    input wire logic detect_drive_o,
    input wire logic notify_out_a_o,
    input wire logic notify_out_b_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic [3:0] lim_q;
    logic [15:0] gap_q;
    logic rise;
    assign rise = active_input_limit_o > lim_q;
    // cycles since the last upward step
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lim_q <= 4'h0;
            gap_q <= 16'hFFFF;
        end else begin
            lim_q <= active_input_limit_o;
            gap_q <= rise ? 16'h0000 : (gap_q == 16'hFFFF ? gap_q : gap_q + 16'h0001);
        end
    end
    sequence collapse_seq;
        below_floor_i && active_input_limit_o == 4'h0 && !attach_drop_comparator_i;
    endsequence
    chk_step_one_code: assert property (rise |-> active_input_limit_o == lim_q + 4'h1)
        else $error("limit rose by more than one code");
    chk_step_spacing_ok: assert property (rise |-> gap_q >= STEP_CYCLES - 1)
        else $error("limit steps closer than the step interval");
    chk_no_rise_below: assert property (below_floor_i |=> !rise)
        else $error("limit rose while input below floor");
    chk_collapse_buck_off: assert property (collapse_seq |-> ##2 !buck_en_o)
        else $error("buck still enabled after collapse at minimum");
    chk_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    chk_unmapped_reads_zero: assert property (reg_rd_i && !(reg_addr_i inside {8'h02, 8'h0F, 8'h3E, 8'h40,
        8'h42, 8'h50}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_detect_needs_usb: assert property (detect_drive_o |-> $past(usb_vbus_i))
        else $error("detection driven without usb supply");
    chk_blink_alternate: assert property (notify_out_a_o |-> !notify_out_b_o)
        else $error("notify outputs high together");
endmodule : charger_input_limit_control_asserts
bind charger_input_limit_control charger_input_limit_control_asserts #(.STEP_CYCLES(STEP_CYCLES)) i_chk (
    .clock_i, .rst_b_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .below_floor_i, .attach_drop_comparator_i,
    .usb_vbus_i, .active_input_limit_o, .buck_en_o, .detect_drive_o, .notify_out_a_o, .notify_out_b_o);

// [supply_model.sv]
// external supply and usb detection line model
`timescale 1ns/1ns
module supply_model (
    input wire logic usb_on_i,
    input wire logic wall_on_i,
    input wire logic [1:0] sag_i,
    input wire logic dedicated_i,
    input wire logic detect_drive_i,
    output logic usb_vbus_o,
    output logic wall_supply_input_o,
    output logic below_floor_o,
    output logic attach_drop_comparator_o,
    output logic dedicated_short_o
);
    assign usb_vbus_o = usb_on_i;
    assign wall_supply_input_o = wall_on_i;
    assign below_floor_o = sag_i != 2'h0;
    assign attach_drop_comparator_o = sag_i != 2'h2;
    // short only visible while the lines are driven
    assign dedicated_short_o = detect_drive_i & dedicated_i;
endmodule : supply_model

// [tb_top.sv]
// self-checking bench for the charger input limit control
`timescale 1ns/1ns
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, v); end end
`define WAIT(c) begin for (int k = 0; k < 300 && !(c); k++) @(negedge clock_i); end
module tb_top;
    logic clock_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, dminus_level_i = 0, supply_fault_i = 0;
    logic battery_ready_i = 0, diode_engaged_i = 1, usb_on = 0, wall_on = 0, dedicated = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, otp_buck_limit_i = 8'h51, otp_limit_set_i = 8'h93;
    logic [7:0] otp_chg_cont_i = 8'h05, rv;
    logic [1:0] sag = 2'h0;
    logic [7:0] regs[5] = '{8'h0F, 8'h3E, 8'h40, 8'h42, 8'h77};
    logic [5:0] cases[3] = '{{2'b01, 4'h3}, {2'b00, 4'h1}, {2'b10, 4'h9}};
    wire logic [7:0] reg_rdata_o;
    wire logic [3:0] active_input_limit_o;
    wire logic [2:0] input_voltage_floor_o;
    wire logic buck_en_o, buck_low_power_o, detect_drive_o, ext_fet_en_o, auto_boot_en_o, reset_mode_o;
    wire logic notify_out_a_o, notify_out_b_o, usb_vbus_i, wall_supply_input_i, below_floor_i;
    wire logic attach_drop_comparator_i, dedicated_short_i;
    int miscompares = 0, tests_run = 0;
    charger_input_limit_control #(.DEBOUNCE_CYCLES(20), .DETECT_CYCLES(8), .STEP_CYCLES(4), .BLINK_CYCLES(4))
        i_charger_input_limit_control (.*);
    supply_model i_supply_model (.usb_on_i(usb_on), .wall_on_i(wall_on), .sag_i(sag), .dedicated_i(dedicated),
        .detect_drive_i(detect_drive_o), .usb_vbus_o(usb_vbus_i), .wall_supply_input_o(wall_supply_input_i),
        .below_floor_o(below_floor_i), .attach_drop_comparator_o(attach_drop_comparator_i),
        .dedicated_short_o(dedicated_short_i));
    initial forever #20 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(negedge clock_i);
        reg_wr_i = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clock_i);
        reg_addr_i = a;
        reg_rd_i = 1;
        @(negedge clock_i);
        reg_rd_i = 0;
        rv = reg_rdata_o;
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clock_i);
        rst_b_i = 1;
        `CHK("reset_mode", 1'b1, reset_mode_o);
        foreach (regs[i]) begin
            rd(regs[i]);
            `CHK("reg_reset", 8'h00, rv);
        end
        wr(8'h0F, 8'h01);
        repeat (2) @(negedge clock_i);
        `CHK("ext_fet", 1'b1, ext_fet_en_o);
        dedicated = 1;
        usb_on = 1;
        repeat (15) @(negedge clock_i);
        `CHK("debounce", 1'b1, reset_mode_o);
        `WAIT(detect_drive_o)
        `CHK("detect", 1'b1, detect_drive_o);
        `WAIT(!detect_drive_o)
        rd(8'h3E);
        `CHK("limit_reg", 8'h53, rv);
        `WAIT(active_input_limit_o == 4'h3)
        `CHK("ramp", 4'h3, active_input_limit_o);
        `CHK("floor", 3'h5, input_voltage_floor_o);
        wr(8'h42, 8'h06);
        repeat (2) @(negedge clock_i);
        `CHK("floor_wr", 3'h6, input_voltage_floor_o);
        sag = 2'h1;
        `WAIT(active_input_limit_o == 4'h0)
        `CHK("sag", 4'h0, active_input_limit_o);
        sag = 2'h2;
        repeat (4) @(negedge clock_i);
        `CHK("collapse", 1'b0, buck_en_o);
        rd(8'h02);
        `CHK("attach_status", 1'b0, rv[input_limit_pkg::ST_ATTACH]);
        sag = 2'h0;
        `WAIT(active_input_limit_o == 4'h3)
        `CHK("recover", 1'b1, buck_en_o);
        wr(8'h3E, 8'h32);
        `WAIT(active_input_limit_o == 4'h2)
        `CHK("host_limit", 4'h2, active_input_limit_o);
        `CHK("low_power", 1'b1, buck_low_power_o);
        wall_on = 1;
        rd(8'h3E);
        rd(8'h3E);
        `CHK("wall_limit", 4'h9, rv[3:0]);
        supply_fault_i = 1;
        `WAIT(reset_mode_o)
        `CHK("fault_reset", 1'b1, reset_mode_o);
        supply_fault_i = 0;
        {usb_on, wall_on} = 2'b00;
        otp_buck_limit_i = 8'h11;
        foreach (cases[i]) begin
            repeat (3) @(negedge clock_i);
            {wall_on, dminus_level_i} = cases[i][5:4];
            usb_on = 1;
            `WAIT(!reset_mode_o)
            rd(8'h3E);
            `CHK("source_limit", cases[i][3:0], rv[3:0]);
            {usb_on, wall_on} = 2'b00;
            `WAIT(reset_mode_o)
        end
        {otp_buck_limit_i, dedicated, usb_on} = {8'h51, 2'b01};
        `WAIT(detect_drive_o)
        `WAIT(!detect_drive_o)
        rd(8'h3E);
        `CHK("std_usb_limit", 8'h51, rv);
        wr(8'h50, 8'h01);
        supply_fault_i = 1;
        repeat (3) @(negedge clock_i);
        supply_fault_i = 0;
        `CHK("emerg_boot", 1'b0, auto_boot_en_o);
        `CHK("emerg_stay", 1'b0, reset_mode_o);
        `WAIT(notify_out_a_o)
        `WAIT(!notify_out_a_o)
        `CHK("blink", 1'b1, notify_out_b_o);
        `CHK("blink_a", 1'b0, notify_out_a_o);
        battery_ready_i = 1;
        repeat (3) @(negedge clock_i);
        `CHK("emerg_exit", 1'b1, auto_boot_en_o);
        wrap_up();
    end
endmodule : tb_top
